// >>> rxfe_pkg.sv
// Package for the receiver front end configuration register bank.
// Assumes a 32-bit APB slave; registers are byte lanes 0 of aligned words.
`default_nettype none
package rxfe_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_DEMOD_AGC   = 8'h0c;
  localparam logic [7:0] IDX_FIRST_GAIN  = 8'h0d;
  localparam logic [7:0] IDX_SECOND_GAIN = 8'h0e;
  localparam logic [7:0] IDX_SQUELCH_TIME = 8'h10;
  localparam logic [7:0] IDX_CONTROL     = 8'h11;
  localparam logic [7:0] IDX_STATUS      = 8'h12;
  // Reset values
  localparam logic [7:0] RST_DEMOD_AGC   = 8'h2c;
  localparam logic [7:0] RST_FIRST_GAIN  = 8'hd8;
  localparam logic [7:0] RST_SECOND_GAIN = 8'h00;
  localparam logic [7:0] RST_SQUELCH_TIME = 8'h00;
  // Field positions in the demodulator / gain control register
  localparam int BIT_DEMOD_MODE = 7;
  localparam int BIT_AMD_SEL    = 6;
  localparam int BIT_SQ_DYN     = 5;
  localparam int BIT_SQ_RATIO   = 4;
  localparam int BIT_AGC_EN     = 3;
  localparam int BIT_AGC_WIN    = 2;
  localparam int BIT_AGC_ALG    = 1;
  localparam int BIT_AGC_RATIO  = 0;
  // Field positions in the first-stage gain register
  localparam int BIT_LF_IN      = 1;
  localparam int BIT_LF_SPLIT   = 0;
  localparam int LSB_AM_G1      = 5;
  localparam int LSB_PM_G1      = 2;
  // Second-stage gain: AM upper nibble, PM lower nibble
  localparam int LSB_AM_G2      = 4;
  localparam int LSB_PM_G2      = 0;
  localparam logic [3:0] G2_MAX_CODE = 4'ha;
  // Control register bits
  localparam int BIT_GAIN_RELOAD = 0;
  // Squelch start delay after end of transmit
  localparam real SQ_DELAY_NS  = 18880.0;
  localparam real CLK_PERIOD_NS = 10.0;
  localparam int  SQ_DELAY_CYC = int'($ceil(SQ_DELAY_NS / CLK_PERIOD_NS));
  localparam logic [10:0] SQ_DELAY_CNT = 11'(SQ_DELAY_CYC);
  localparam logic [10:0] CNT_ONE   = 11'h001;
  localparam logic [10:0] CNT_ZERO  = 11'h000;
  typedef enum logic [1:0] {RXFE_SQ_IDLE, RXFE_SQ_WAIT, RXFE_SQ_ACTIVE} rxfe_sq_e;
endpackage
`default_nettype wire

// >>> rxfe_squelch.sv
// Squelch sequencer: delayed start after transmit end, stop on mask timer.
// Assumes tx_end is a one-cycle pulse and mask_timer counts in the same units as sq_time.
`default_nettype none
module rxfe_squelch
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       tx_end,
  input  wire logic [7:0] mask_timer,
  input  wire logic [7:0] sq_time,
  output logic            active
);
  rxfe_pkg::rxfe_sq_e state;
  rxfe_pkg::rxfe_sq_e next_state;
  logic [10:0]        cnt;
  logic [10:0]        next_cnt;
  wire                delay_done = (cnt == rxfe_pkg::CNT_ONE);
  wire                timer_hit  = (mask_timer >= sq_time);

  ////////////////////////////////////////////////////////////////////////
  // Next state; disabling drops squelch at once
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    unique case (state)
      rxfe_pkg::RXFE_SQ_IDLE:
      begin
        if (enable && tx_end)
        begin
          next_state = rxfe_pkg::RXFE_SQ_WAIT;
          next_cnt   = rxfe_pkg::SQ_DELAY_CNT;
        end
      end
      rxfe_pkg::RXFE_SQ_WAIT:
      begin
        next_cnt = cnt - rxfe_pkg::CNT_ONE;
        if (delay_done)
          next_state = rxfe_pkg::RXFE_SQ_ACTIVE;
      end
      rxfe_pkg::RXFE_SQ_ACTIVE:
      begin
        if (timer_hit)
          next_state = rxfe_pkg::RXFE_SQ_IDLE;
      end
    endcase
    if (!enable)
    begin
      next_state = rxfe_pkg::RXFE_SQ_IDLE;
      next_cnt   = rxfe_pkg::CNT_ZERO;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state  <= rxfe_pkg::RXFE_SQ_IDLE;
      cnt    <= rxfe_pkg::CNT_ZERO;
      active <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      cnt    <= next_cnt;
      active <= (next_state == rxfe_pkg::RXFE_SQ_ACTIVE);
    end
  end
endmodule
`default_nettype wire

// >>> rxfe_regs.sv
// Receiver front end configuration register bank with APB slave.
// Assumes the analog path samples the config outputs; tx_end is a one-cycle pulse.
`default_nettype none

module rxfe_regs
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        tx_end,
  input  wire logic [7:0]  mask_timer,
  output logic             iq_demod_sel,
  output logic             am_mixer_sel,
  output logic             squelch_active,
  output logic             squelch_ratio_sel,
  output logic             gain_ctrl_enable,
  output logic             gain_ctrl_full_window,
  output logic             gain_ctrl_reset_alg,
  output logic             gain_ctrl_ratio_sel,
  output logic [2:0]       am_first_stage_gain,
  output logic [2:0]       pm_first_stage_gain,
  output logic             low_freq_input_sel,
  output logic             low_freq_split_sel,
  output logic [3:0]       am_second_stage_gain,
  output logic [3:0]       pm_second_stage_gain
);
  logic       rst_meta;
  logic       rst_n;
  logic [7:0] demod_agc;
  logic [7:0] first_gain;
  logic [7:0] second_gain;
  logic [7:0] squelch_time;
  logic       sq_act;

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode; word index is the byte address over four
  wire [7:0] word_idx = paddr[9:2];
  wire       hi_zero  = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'h0);
  wire       hit_da   = hi_zero && (word_idx == rxfe_pkg::IDX_DEMOD_AGC);
  wire       hit_fg   = hi_zero && (word_idx == rxfe_pkg::IDX_FIRST_GAIN);
  wire       hit_sg   = hi_zero && (word_idx == rxfe_pkg::IDX_SECOND_GAIN);
  wire       hit_st   = hi_zero && (word_idx == rxfe_pkg::IDX_SQUELCH_TIME);
  wire       hit_ct   = hi_zero && (word_idx == rxfe_pkg::IDX_CONTROL);
  wire       hit_ss   = hi_zero && (word_idx == rxfe_pkg::IDX_STATUS);
  wire       mapped   = hit_da | hit_fg | hit_sg | hit_st | hit_ct | hit_ss;
  // Access phase completes two cycles after penable rises, after one wait state
  wire       access   = psel && penable && !pready;
  wire       wr_ok    = access && pwrite && mapped && pstrb[0];
  wire       wr_da    = wr_ok && hit_da;
  wire       wr_fg    = wr_ok && hit_fg;
  wire       wr_sg    = wr_ok && hit_sg;
  wire       wr_st    = wr_ok && hit_st;
  // Reload command is a write of 1 to the control bit, self-clearing
  wire       reload   = wr_ok && hit_ct && pwdata[rxfe_pkg::BIT_GAIN_RELOAD];
  wire [7:0] status   = {4'h0, am_second_stage_gain != second_gain[7:4],
                         pm_second_stage_gain != second_gain[3:0], 1'b0, sq_act};
  wire [7:0] rd_byte  = hit_da ? demod_agc :
                        hit_fg ? first_gain :
                        hit_sg ? second_gain :
                        hit_st ? squelch_time :
                        hit_ss ? status : 8'h00;

  // Bus handshake flops; unmapped address answers with an error
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= access;
      pslverr <= access && !mapped;
      prdata  <= (access && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration storage; byte lane 0 only
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      demod_agc    <= rxfe_pkg::RST_DEMOD_AGC;
      first_gain   <= rxfe_pkg::RST_FIRST_GAIN;
      second_gain  <= rxfe_pkg::RST_SECOND_GAIN;
      squelch_time <= rxfe_pkg::RST_SQUELCH_TIME;
    end
    else
    begin
      if (wr_da)
        demod_agc <= pwdata[7:0];
      if (wr_fg)
        first_gain <= pwdata[7:0];
      if (wr_sg)
        second_gain <= pwdata[7:0]; // all codes stored as written
      if (wr_st)
        squelch_time <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Working second-stage gain; a plain write leaves it alone
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      am_second_stage_gain <= rxfe_pkg::RST_SECOND_GAIN[7:4];
      pm_second_stage_gain <= rxfe_pkg::RST_SECOND_GAIN[3:0];
    end
    else if (reload)
    begin
      am_second_stage_gain <= second_gain[rxfe_pkg::LSB_AM_G2 +: 4];
      pm_second_stage_gain <= second_gain[rxfe_pkg::LSB_PM_G2 +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered copies of the configuration fields for the analog path
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      iq_demod_sel          <= 1'b0;
      am_mixer_sel          <= 1'b0;
      squelch_ratio_sel     <= 1'b0;
      gain_ctrl_enable      <= 1'b1;
      gain_ctrl_full_window <= 1'b1;
      gain_ctrl_reset_alg   <= 1'b0;
      gain_ctrl_ratio_sel   <= 1'b0;
      am_first_stage_gain   <= rxfe_pkg::RST_FIRST_GAIN[7:5];
      pm_first_stage_gain   <= rxfe_pkg::RST_FIRST_GAIN[4:2];
      low_freq_input_sel    <= 1'b0;
      low_freq_split_sel    <= 1'b0;
      squelch_active        <= 1'b0;
    end
    else
    begin
      iq_demod_sel          <= demod_agc[rxfe_pkg::BIT_DEMOD_MODE];
      am_mixer_sel          <= demod_agc[rxfe_pkg::BIT_AMD_SEL];
      squelch_ratio_sel     <= demod_agc[rxfe_pkg::BIT_SQ_RATIO];
      gain_ctrl_enable      <= demod_agc[rxfe_pkg::BIT_AGC_EN];
      gain_ctrl_full_window <= demod_agc[rxfe_pkg::BIT_AGC_WIN];
      gain_ctrl_reset_alg   <= demod_agc[rxfe_pkg::BIT_AGC_ALG];
      gain_ctrl_ratio_sel   <= demod_agc[rxfe_pkg::BIT_AGC_RATIO];
      am_first_stage_gain   <= first_gain[rxfe_pkg::LSB_AM_G1 +: 3];
      pm_first_stage_gain   <= first_gain[rxfe_pkg::LSB_PM_G1 +: 3];
      low_freq_input_sel    <= first_gain[rxfe_pkg::BIT_LF_IN];
      low_freq_split_sel    <= first_gain[rxfe_pkg::BIT_LF_SPLIT];
      squelch_active        <= sq_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Squelch timing sequencer
  rxfe_squelch u_squelch
  (
    .clk        (mclk),
    .rst_n      (rst_n),
    .enable     (demod_agc[rxfe_pkg::BIT_SQ_DYN]),
    .tx_end     (tx_end),
    .mask_timer (mask_timer),
    .sq_time    (squelch_time),
    .active     (sq_act)
  );
endmodule
`default_nettype wire

// >>> rxfe_regs_chk.sv
// Assertion checker for the receiver front end register bank.
// Assumes it is bound to rxfe_regs, ports by name, one clock mclk.
`default_nettype none
module rxfe_regs_chk
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        tx_end,
  input wire logic        squelch_active,
  input wire logic        iq_demod_sel,
  input wire logic        am_mixer_sel,
  input wire logic        squelch_ratio_sel,
  input wire logic        gain_ctrl_enable,
  input wire logic        gain_ctrl_full_window,
  input wire logic        gain_ctrl_reset_alg,
  input wire logic        gain_ctrl_ratio_sel,
  input wire logic [2:0]  am_first_stage_gain,
  input wire logic [2:0]  pm_first_stage_gain,
  input wire logic        low_freq_input_sel,
  input wire logic        low_freq_split_sel,
  input wire logic [3:0]  am_second_stage_gain,
  input wire logic [3:0]  pm_second_stage_gain
);
  timeunit 1ns;
  timeprecision 1ps;
  // Write taken at its deciding edge; strobe-less writes do not count
  wire logic        wr     = psel && penable && pwrite && !pready && pstrb[0];
  wire logic        reload = wr && paddr == 32'h44 && pwdata[0];
  logic      [10:0] since_tx;
  // Cycles since end of transmit; saturates so idle time never wraps
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn) since_tx <= 11'h7ff;
    else if (tx_end) since_tx <= 11'h000;
    else if (since_tx != 11'h7ff) since_tx <= since_tx + 11'h001;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  a_wait_state: assert property (psel && penable && !$past(penable) |=> pready) // Bus timing
    else $error("pready not after one wait state");
  a_one_pulse: assert property (pready |=> !pready) // Bus timing
    else $error("pready longer than one cycle");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0) // Bus refusal
    else $error("refused access returned data");
  a_demod_copy: assert property (wr && paddr == 32'h30 |-> ##2
    {iq_demod_sel, am_mixer_sel, squelch_ratio_sel} == {$past(pwdata[7:6], 2), $past(pwdata[4], 2)})
    else $error("demodulator selects wrong");
  a_agc_copy: assert property (wr && paddr == 32'h30 |-> ##2
    {gain_ctrl_enable, gain_ctrl_full_window, gain_ctrl_reset_alg, gain_ctrl_ratio_sel}
    == $past(pwdata[3:0], 2)) else $error("gain control bits wrong");
  a_first_copy: assert property (wr && paddr == 32'h34 |-> ##2
    {am_first_stage_gain, pm_first_stage_gain, low_freq_input_sel, low_freq_split_sel}
    == $past(pwdata[7:0], 2)) else $error("first stage fields wrong");
  a_gain_hold: assert property ($changed({am_second_stage_gain, pm_second_stage_gain})
    |-> $past(reload) || $past(reload, 2)) else $error("working gain moved without reload");
  a_sq_start: assert property ($rose(squelch_active)
    |-> since_tx inside {[11'h760:11'h762]}) else $error("squelch start off delay");
  a_reset_dflt: assert property ($rose(resetn) |-> gain_ctrl_enable &&
    gain_ctrl_full_window && !iq_demod_sel && !am_mixer_sel && !low_freq_input_sel
    && am_first_stage_gain == 3'h6 && pm_first_stage_gain == 3'h6)
    else $error("reset defaults wrong");
  c_reload: cover property (reload);
  c_sq: cover property ($rose(squelch_active));
  c_err: cover property (pready && pslverr);
endmodule
bind rxfe_regs rxfe_regs_chk chk (.*);
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the receiver front end register bank.
// Assumes the APB slave answers with one wait state and the checker is bound.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic w; logic [31:0] a; logic [7:0] d;} rxfe_row_s;
  logic        mclk, resetn, psel, penable, pwrite, tx_end, pready, pslverr, er;
  logic        iq_demod_sel, am_mixer_sel, squelch_active, squelch_ratio_sel;
  logic        gain_ctrl_enable, gain_ctrl_full_window, gain_ctrl_reset_alg;
  logic        gain_ctrl_ratio_sel, low_freq_input_sel, low_freq_split_sel;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb, am_second_stage_gain, pm_second_stage_gain;
  logic [2:0]  am_first_stage_gain, pm_first_stage_gain;
  logic [7:0]  mask_timer;
  int          num_errors, n_checks, cyc, n;
  // Reads of defaults first, then writes read back; those to 0x30 and 0x34 also seen at the outputs
  rxfe_row_s   rows [11] = '{'{0, 32'h30, 8'h2c}, '{0, 32'h34, 8'hd8}, '{0, 32'h38, 8'h00},
    '{1, 32'h30, 8'hc0}, '{1, 32'h30, 8'h1f}, '{1, 32'h30, 8'h0a}, '{1, 32'h34, 8'he0},
    '{1, 32'h34, 8'h1f}, '{1, 32'h34, 8'h24}, '{1, 32'h38, 8'ha5}, '{1, 32'h40, 8'h10}};
  rxfe_regs dut (.*);
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic pulse_tx;
    @(posedge mclk);
    tx_end <= 1'b1;
    @(posedge mclk);
    tx_end <= 1'b0;
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog well beyond the two long squelch waits
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      num_errors++;
      tally_and_finish;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {resetn, psel, penable, pwrite, tx_end, paddr, pwdata, mask_timer} = '0;
    pstrb = 4'hf;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (rows[i])
    begin
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].d);
      if (rows[i].w && rows[i].a == 32'h30) chk({iq_demod_sel, am_mixer_sel, squelch_ratio_sel,
        gain_ctrl_enable, gain_ctrl_full_window, gain_ctrl_reset_alg, gain_ctrl_ratio_sel},
        {rows[i].d[7:6], rows[i].d[4:0]});
      if (rows[i].w && rows[i].a == 32'h34) chk({am_first_stage_gain, pm_first_stage_gain,
        low_freq_input_sel, low_freq_split_sel}, rows[i].d);
    end
    // Working gain moves only on the reload command, and only then
    chk({am_second_stage_gain, pm_second_stage_gain}, 8'h00);
    apb(1'b1, 32'h44, 32'h1);
    repeat (3) @(posedge mclk);
    chk({am_second_stage_gain, pm_second_stage_gain}, 8'ha5);
    apb(1'b1, 32'h38, 32'h0);
    repeat (3) @(posedge mclk);
    chk({am_second_stage_gain, pm_second_stage_gain}, 8'ha5);
    // Status shows both working codes now differ from the register
    apb(1'b0, 32'h48, 32'h0);
    chk(rd, 32'h0c);
    // Refusals: unmapped, misaligned, strobe off leaves the register alone
    apb(1'b0, 32'h3c, 32'h0);
    chk({er, rd[7:0]}, 9'h100);
    apb(1'b0, 32'h31, 32'h0);
    chk(er, 1'b1);
    pstrb <= 4'h0;
    apb(1'b1, 32'h34, 32'hff);
    pstrb <= 4'hf;
    apb(1'b0, 32'h34, 32'h0);
    chk(rd, 32'h24);
    // Dynamic squelch: exact start delay, then stop on mask timer
    apb(1'b1, 32'h30, 32'h2c);
    pulse_tx;
    n = 0;
    while (squelch_active !== 1'b1 && n < 3000)
    begin
      @(posedge mclk);
      #1 n++;
    end
    chk(n, 1889);
    // Back onto the rising edge before driving again
    @(posedge mclk);
    mask_timer <= 8'h10;
    repeat (4) @(posedge mclk);
    chk(squelch_active, 1'b0);
    // Squelch bit off: no squelch at all
    apb(1'b1, 32'h30, 32'h0c);
    mask_timer <= 8'h00;
    pulse_tx;
    repeat (1900) @(posedge mclk);
    chk(squelch_active, 1'b0);
    // Second reset in mid-run restores defaults
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    apb(1'b0, 32'h30, 32'h0);
    chk(rd, 32'h2c);
    tally_and_finish;
  end
endmodule
`default_nettype wire
